// [hw/tw_eeprom.sv]
`include "tw_params.svh"

module tw_eeprom import tw_pkg::*; #(
    parameter bit FIVE_VOLT        = 1'b0,
    parameter int WRITE_CYCLES     = (FIVE_VOLT ? `TW_T_WC_5V_US : `TW_T_WC_LV_US) * `TW_MCLK_MHZ,
    parameter int ERASE_ALL_CYCLES = `TW_T_EC_US * `TW_MCLK_MHZ,
    parameter int WRITE_ALL_CYCLES = `TW_T_WL_US * `TW_MCLK_MHZ
) (
    // System clock domain
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    // Serial link
    input  wire logic link_clk,
    input  wire logic chip_select,
    input  wire logic serial_in,
    output logic      data_out,
    output logic      data_out_oe_n,
    // Configuration
    input  wire logic word_width_select
);

    localparam int TW = 21;

    ////////////////////////////////////////////////////////////////////////////
    // Storage; contents change only while a programming cycle is busy

    logic [7:0]    mem_q [0:`TW_MEM_BYTES-1];

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: frame parsing, held in reset while chip select is low; command words reset by reset_n only

    logic [1:0]    org_sync_q;
    logic          started_q;
    logic          done_q;
    logic [4:0]    cnt_q;
    logic [1:0]    op_q;
    logic [1:0]    top_q;
    logic [6:0]    addr_q;
    logic [15:0]   data_q;
    logic          rd_act_q;
    logic          rd_bit_q;
    logic [3:0]    rd_idx_q;
    logic [6:0]    rd_addr_q;
    logic          cmd_tog_q;
    tw_cmd_t       cmd_kind_q;
    logic [6:0]    cmd_addr_q;
    logic [15:0]   cmd_data_q;
    logic          cmd_wide_q;

    always_ff @(posedge link_clk) begin
        org_sync_q <= {org_sync_q[0], word_width_select};
    end

    wire           wide       = org_sync_q[1];
    wire  [4:0]    abits      = wide ? `TW_ABITS_X16 : `TW_ABITS_X8;
    wire  [4:0]    dbits      = wide ? `TW_DBITS_X16 : `TW_DBITS_X8;
    wire           parsing    = started_q && !done_q;
    wire  [4:0]    n          = cnt_q + 5'h01;
    wire           in_addr    = parsing && (n > 5'h02) && (n <= 5'h02 + abits);
    wire           in_data    = parsing && (n > 5'h02 + abits) && (n <= 5'h02 + abits + dbits);
    wire           last_addr  = parsing && (n == 5'h02 + abits);
    wire           pre_last   = parsing && (n == 5'h01 + abits);
    wire           last_data  = parsing && (n == 5'h02 + abits + dbits);
    wire  [6:0]    addr_nx    = wide ? {1'b0, addr_q[4:0], serial_in} : {addr_q[5:0], serial_in};
    wire  [15:0]   data_nx    = {data_q[14:0], serial_in};
    wire           op_read    = op_q == `TW_OP_READ;
    wire           op_write   = op_q == `TW_OP_WRITE;
    wire           op_erase   = op_q == `TW_OP_ERASE;
    wire           op_ext     = op_q == `TW_OP_EXT;
    wire           ext_en     = op_ext && top_q == `TW_EXT_ENABLE;
    wire           ext_dis    = op_ext && top_q == `TW_EXT_DISABLE;
    wire           ext_erase_all_cmd   = op_ext && top_q == `TW_EXT_ERASE_ALL_CMD;
    wire           ext_write_all_cmd   = op_ext && top_q == `TW_EXT_WRITE_ALL_CMD;
    wire           erase_pt   = FIVE_VOLT ? pre_last : last_addr;
    wire           fire_erase = op_erase && erase_pt;
    wire           fire_erase_all_cmd  = ext_erase_all_cmd && erase_pt;
    wire           fire_write = op_write && last_data;
    wire           fire_write_all_cmd  = ext_write_all_cmd && last_data;
    wire           fire_en    = ext_en && last_addr;
    wire           fire_dis   = ext_dis && last_addr;
    wire           rd_start   = op_read && last_addr;
    wire           fire       = fire_erase | fire_erase_all_cmd | fire_write | fire_write_all_cmd
                                | fire_en | fire_dis;
    wire           done_now   = ((op_write || ext_write_all_cmd) ? last_data : last_addr);
    wire  [3:0]    rd_msb     = wide ? 4'hF : 4'h7;
    wire  [6:0]    rd_addr_up = wide ? {1'b0, rd_addr_q[5:0] + 6'h01} : rd_addr_q + 7'h01;
    wire  [15:0]   rd_word    = wide ? {mem_q[{rd_addr_q[5:0], 1'b0}],
                                        mem_q[{rd_addr_q[5:0], 1'b1}]}
                                     : {8'h00, mem_q[rd_addr_q]};

    tw_cmd_t       fire_kind;
    assign fire_kind = fire_erase ? TW_CMD_ERASE :
                       fire_erase_all_cmd  ? TW_CMD_ERASE_ALL_CMD  :
                       fire_write ? TW_CMD_WRITE :
                       fire_write_all_cmd  ? TW_CMD_WRITE_ALL_CMD  :
                       fire_en    ? TW_CMD_ENABLE : TW_CMD_DISABLE;

    always_ff @(posedge link_clk or negedge chip_select) begin
        if (!chip_select) begin
            started_q <= 1'b0;
            done_q    <= 1'b0;
            cnt_q     <= 5'h00;
            op_q      <= 2'h0;
            top_q     <= 2'h0;
            addr_q    <= 7'h00;
            data_q    <= 16'h0000;
        end else if (!started_q) begin
            started_q <= serial_in;
        end else if (!done_q) begin
            cnt_q <= n;
            if (n <= 5'h02) begin
                op_q <= {op_q[0], serial_in};
            end
            if (n == 5'h03 || n == 5'h04) begin
                top_q <= {top_q[0], serial_in};
            end
            if (in_addr) begin
                addr_q <= addr_nx;
            end
            if (in_data) begin
                data_q <= data_nx;
            end
            if (done_now) begin
                done_q <= 1'b1;
            end
        end
    end

    // Read streaming: dummy zero first, then MSB-first words with address wrap
    always_ff @(posedge link_clk or negedge chip_select) begin
        if (!chip_select) begin
            rd_act_q  <= 1'b0;
            rd_bit_q  <= 1'b0;
            rd_idx_q  <= 4'h0;
            rd_addr_q <= 7'h00;
        end else if (rd_start) begin
            rd_act_q  <= 1'b1;
            rd_bit_q  <= 1'b0;
            rd_idx_q  <= rd_msb;
            rd_addr_q <= addr_nx;
        end else if (rd_act_q) begin
            rd_bit_q <= rd_word[rd_idx_q];
            if (rd_idx_q == 4'h0) begin
                rd_idx_q  <= rd_msb;
                rd_addr_q <= rd_addr_up;
            end else begin
                rd_idx_q <= rd_idx_q - 4'h1;
            end
        end
    end

    // Command words survive chip select low so the slow side can take them
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_tog_q  <= 1'b0;
            cmd_kind_q <= TW_CMD_NONE;
            cmd_addr_q <= 7'h00;
            cmd_data_q <= 16'h0000;
            cmd_wide_q <= 1'b0;
        end else begin
            if (fire) begin
                cmd_tog_q  <= ~cmd_tog_q;
                cmd_kind_q <= fire_kind;
                cmd_wide_q <= wide;
            end
            if (in_addr) begin
                cmd_addr_q <= addr_nx;
            end
            if (last_data) begin
                cmd_data_q <= data_nx;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System domain: crossings

    logic [1:0]    cs_sync_q;
    logic [1:0]    tog_sync_q;
    logic [1:0]    start_sync_q;
    logic [1:0]    rdact_sync_q;
    logic [1:0]    rdbit_sync_q;
    logic          tog_seen_q;
    logic          cs_prev_q;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cs_sync_q    <= 2'h0;
            tog_sync_q   <= 2'h0;
            start_sync_q <= 2'h0;
            rdact_sync_q <= 2'h0;
            rdbit_sync_q <= 2'h0;
        end else if (clk_en) begin
            cs_sync_q    <= {cs_sync_q[0], chip_select};
            tog_sync_q   <= {tog_sync_q[0], cmd_tog_q};
            start_sync_q <= {start_sync_q[0], started_q};
            rdact_sync_q <= {rdact_sync_q[0], rd_act_q};
            rdbit_sync_q <= {rdbit_sync_q[0], rd_bit_q};
        end
    end

    wire           cs_s     = cs_sync_q[1];
    wire           cs_fall  = cs_prev_q && !cs_s;
    wire           cs_rise  = !cs_prev_q && cs_s;
    wire           new_cmd  = tog_sync_q[1] != tog_seen_q;

    ////////////////////////////////////////////////////////////////////////////
    // System domain: programming sequencer

    tw_state_t     state_q;
    logic          enable_q;
    tw_cmd_t       kind_q;
    logic [15:0]   pdata_q;
    logic          pwide_q;
    logic [TW-1:0] timer_q;
    logic          armed_q;
    logic          clr_pend_q;
    logic [5:0]    low_cnt_q;
    logic          low_ok_q;

    wire           prog_kind = cmd_kind_q inside {TW_CMD_WRITE, TW_CMD_ERASE,
                                                  TW_CMD_ERASE_ALL_CMD, TW_CMD_WRITE_ALL_CMD};
    wire           idle_cmd  = new_cmd && state_q == TW_IDLE;
    wire           start_ok  = idle_cmd && prog_kind && enable_q;
    wire           go_busy   = (start_ok && FIVE_VOLT)
                               || (state_q == TW_WAIT_CS && cs_fall);
    wire           finish    = state_q == TW_BUSY && timer_q == TW'(1);
    wire           busy      = state_q == TW_BUSY;
    wire [TW-1:0]  cyc_sel   = kind_q == TW_CMD_ERASE_ALL_CMD ? TW'(ERASE_ALL_CYCLES) :
                               kind_q == TW_CMD_WRITE_ALL_CMD ? TW'(WRITE_ALL_CYCLES) :
                                                       TW'(WRITE_CYCLES);
    wire [6:0]     hi_byte   = {cmd_addr_q[5:0], 1'b0};
    wire [6:0]     lo_byte   = {cmd_addr_q[5:0], 1'b1};

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_q    <= TW_IDLE;
            enable_q   <= 1'b0;
            kind_q     <= TW_CMD_NONE;
            pdata_q    <= 16'h0000;
            pwide_q    <= 1'b0;
            timer_q    <= '0;
            tog_seen_q <= 1'b0;
            cs_prev_q  <= 1'b0;
        end else if (clk_en) begin
            tog_seen_q <= tog_sync_q[1];
            cs_prev_q  <= cs_s;
            if (idle_cmd && cmd_kind_q == TW_CMD_ENABLE) begin
                enable_q <= 1'b1;
            end
            if (idle_cmd && cmd_kind_q == TW_CMD_DISABLE) begin
                enable_q <= 1'b0;
            end
            if (start_ok) begin
                kind_q  <= cmd_kind_q;
                pdata_q <= cmd_data_q;
                pwide_q <= cmd_wide_q;
            end
            unique case (state_q)
                TW_IDLE: begin
                    if (start_ok) begin
                        state_q <= FIVE_VOLT ? TW_BUSY : TW_WAIT_CS;
                        timer_q <= FIVE_VOLT ? (cmd_kind_q == TW_CMD_ERASE_ALL_CMD ? TW'(ERASE_ALL_CYCLES) :
                                                cmd_kind_q == TW_CMD_WRITE_ALL_CMD ? TW'(WRITE_ALL_CYCLES) :
                                                TW'(WRITE_CYCLES)) : timer_q;
                    end
                end
                TW_WAIT_CS: begin
                    if (cs_fall) begin
                        state_q <= TW_BUSY;
                        timer_q <= cyc_sel;
                    end
                end
                TW_BUSY: begin
                    timer_q <= timer_q - TW'(1);
                    if (finish) begin
                        state_q <= TW_IDLE;
                    end
                end
            endcase
        end
    end

    // Array update at the end of the self-timed cycle
    always_ff @(posedge mclk) begin
        if (reset_n && clk_en && finish) begin
            unique case (kind_q)
                TW_CMD_ERASE: begin
                    mem_q[pwide_q ? hi_byte : cmd_addr_q] <= `TW_ERASED_BYTE;
                    if (pwide_q) begin
                        mem_q[lo_byte] <= `TW_ERASED_BYTE;
                    end
                end
                TW_CMD_WRITE: begin
                    mem_q[pwide_q ? hi_byte : cmd_addr_q] <= pwide_q ? pdata_q[15:8]
                                                                     : pdata_q[7:0];
                    if (pwide_q) begin
                        mem_q[lo_byte] <= pdata_q[7:0];
                    end
                end
                TW_CMD_ERASE_ALL_CMD: begin
                    for (int i = 0; i < `TW_MEM_BYTES; i++) begin
                        mem_q[i] <= `TW_ERASED_BYTE;
                    end
                end
                TW_CMD_WRITE_ALL_CMD: begin
                    for (int i = 0; i < `TW_MEM_BYTES; i++) begin
                        mem_q[i] <= (pwide_q && !i[0]) ? pdata_q[15:8] : pdata_q[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status and data-out pin

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            armed_q    <= 1'b0;
            clr_pend_q <= 1'b0;
            low_cnt_q  <= 6'h00;
            low_ok_q   <= 1'b0;
        end else if (clk_en) begin
            if (go_busy) begin
                armed_q <= 1'b1;
            end else if (cs_fall && clr_pend_q) begin
                armed_q <= 1'b0;
            end
            if (cs_fall) begin
                clr_pend_q <= 1'b0;
            end else if (start_sync_q[1] && !busy && armed_q) begin
                clr_pend_q <= 1'b1;
            end
            if (cs_s) begin
                low_cnt_q <= 6'h00;
            end else if (low_cnt_q != 6'h3F) begin
                low_cnt_q <= low_cnt_q + 6'h01;
            end
            if (cs_rise) begin
                low_ok_q <= low_cnt_q >= 6'(`TW_CSL_CYCLES);
            end
        end
    end

    wire           drive_rd = cs_s && rdact_sync_q[1];
    wire           drive_st = cs_s && armed_q && low_ok_q && !rdact_sync_q[1];
    wire           out_d    = drive_rd ? rdbit_sync_q[1] : !busy;
    wire           oe_n_d   = !(drive_rd || drive_st);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            data_out      <= 1'b0;
            data_out_oe_n <= 1'b1;
        end else if (clk_en) begin
            data_out      <= out_d;
            data_out_oe_n <= oe_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_disabled_ignored: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && idle_cmd && prog_kind && !enable_q) |=> state_q == TW_IDLE)
        else $error("programming started while disabled");

    a_enable_holds: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (enable_q && !(idle_cmd && cmd_kind_q == TW_CMD_DISABLE)) |=> enable_q)
        else $error("enable lost without disable");

    a_lv_waits_cs: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (!FIVE_VOLT && clk_en && start_ok) |=> state_q == TW_WAIT_CS)
        else $error("low-voltage cycle did not wait for select fall");

    a_fivev_starts: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (FIVE_VOLT && clk_en && start_ok) |=> busy && timer_q == cyc_sel)
        else $error("five-volt cycle did not start at once");

    a_timer_counts: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && busy && !finish) |=> busy && timer_q == $past(timer_q) - TW'(1))
        else $error("self-timed cycle stalled");

    a_status_level: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && drive_st) |=> !data_out_oe_n && data_out == !$past(busy))
        else $error("status level wrong");

    a_status_clear: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && cs_fall && clr_pend_q && !go_busy) |=> !armed_q)
        else $error("status not cleared");

    a_release_low: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && !cs_s) |=> data_out_oe_n)
        else $error("data-out driven while deselected");

    a_erase_ones: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && finish && kind_q == TW_CMD_ERASE && !pwide_q)
        |=> mem_q[$past(cmd_addr_q)] == `TW_ERASED_BYTE)
        else $error("erased byte not all ones");

endmodule

// [hw/tw_params.svh]
`ifndef TW_PARAMS_SVH
`define TW_PARAMS_SVH

`define TW_MCLK_MHZ      125
`define TW_MCLK_NS       8
`define TW_T_WC_LV_US    6000
`define TW_T_WC_5V_US    2000
`define TW_T_EC_US       6000
`define TW_T_WL_US       15000
`define TW_T_CSL_NS      250
`define TW_CSL_CYCLES    ((`TW_T_CSL_NS + `TW_MCLK_NS - 1) / `TW_MCLK_NS)

`define TW_OP_EXT        2'h0
`define TW_OP_WRITE      2'h1
`define TW_OP_READ       2'h2
`define TW_OP_ERASE      2'h3
`define TW_EXT_DISABLE   2'h0
`define TW_EXT_WRITE_ALL_CMD      2'h1
`define TW_EXT_ERASE_ALL_CMD      2'h2
`define TW_EXT_ENABLE    2'h3

`define TW_ABITS_X8      5'h07
`define TW_ABITS_X16     5'h06
`define TW_DBITS_X8      5'h08
`define TW_DBITS_X16     5'h10
`define TW_ERASED_BYTE   8'hFF
`define TW_MEM_BYTES     128

`endif

// [hw/tw_pkg.sv]
package tw_pkg;
    typedef enum logic [2:0] {
        TW_CMD_NONE,
        TW_CMD_READ,
        TW_CMD_WRITE,
        TW_CMD_ERASE,
        TW_CMD_ERASE_ALL_CMD,
        TW_CMD_WRITE_ALL_CMD,
        TW_CMD_ENABLE,
        TW_CMD_DISABLE
    } tw_cmd_t;

    typedef enum logic [1:0] {
        TW_IDLE,
        TW_WAIT_CS,
        TW_BUSY
    } tw_state_t;
endpackage

// [tb/tb.sv]
`include "tw_params.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int CYC = 200;
    logic mclk;
    logic reset_n;
    logic word_width_select;
    wire  link_clk;
    wire  chip_select;
    wire  serial_in;
    wire  data_out;
    wire  data_out_oe_n;
    int   mismatches = 0;
    int   num_checks = 0;

    tw_eeprom #(.FIVE_VOLT(1'b0), .WRITE_CYCLES(CYC), .ERASE_ALL_CYCLES(CYC),
        .WRITE_ALL_CYCLES(CYC)) dut (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1),
        .link_clk(link_clk), .chip_select(chip_select), .serial_in(serial_in),
        .data_out(data_out), .data_out_oe_n(data_out_oe_n),
        .word_width_select(word_width_select));

    tw_host host (.link_clk(link_clk), .chip_select(chip_select), .serial_in(serial_in),
        .data_out(data_out), .data_out_oe_n(data_out_oe_n));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmd(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d,
                       input bit wd);
        int w;
        logic [31:0] v;
        w = word_width_select ? 16 : 8;
        v = word_width_select ? {7'h0, 1'b1, op, a[5:0], d} : {14'h0, 1'b1, op, a, d[7:0]};
        if (!wd) v = v >> w;
        host.send(v, (word_width_select ? 9 : 10) + (wd ? w : 0));
    endtask

    task automatic ext(input logic [1:0] code);
        cmd(`TW_OP_EXT, word_width_select ? {1'b0, code, 4'h0} : {code, 5'h0}, 16'h0, 1'b0);
        host.deselect();
    endtask

    // Launch by deselect, see busy then ready, then clear the status
    task automatic poll_done();
        host.deselect();
        host.select();
        `CHK(data_out_oe_n, 1'b0)
        `CHK(data_out, 1'b0)
        #(CYC * 8 + 400);
        `CHK(data_out, 1'b1)
        host.pulse(1'b1);
        host.deselect();
        host.select();
        `CHK(data_out_oe_n, 1'b1)
        host.deselect();
    endtask

    task automatic no_status();
        host.deselect();
        host.select();
        `CHK(data_out_oe_n, 1'b1)
        host.deselect();
    endtask

    task automatic rd(input logic [6:0] a, input int n, input logic [31:0] e);
        logic [31:0] m;
        cmd(`TW_OP_READ, a, 16'h0, 1'b0);
        repeat (n) host.pulse(1'b0);
        m = (32'h1 << (n + 1)) - 32'h1;
        `CHK(host.rx & m, e)
        host.deselect();
        `CHK(data_out_oe_n, 1'b1)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_power_up();
        cmd(`TW_OP_WRITE, 7'h05, 16'h0011, 1'b1);
        no_status();
        cmd(`TW_OP_EXT, {`TW_EXT_WRITE_ALL_CMD, 5'h0}, 16'h0022, 1'b1);
        no_status();
    endtask

    task automatic t_write_read();
        ext(`TW_EXT_ENABLE);
        cmd(`TW_OP_WRITE, 7'h05, 16'h003C, 1'b1);
        poll_done();
        cmd(`TW_OP_WRITE, 7'h06, 16'h00C3, 1'b1);
        poll_done();
        rd(7'h05, 16, 32'h3CC3);
    endtask

    task automatic t_erase();
        cmd(`TW_OP_ERASE, 7'h06, 16'h0, 1'b0);
        poll_done();
        rd(7'h05, 16, 32'h3CFF);
    endtask

    task automatic t_bulk();
        cmd(`TW_OP_EXT, {`TW_EXT_WRITE_ALL_CMD, 5'h0}, 16'h005A, 1'b1);
        poll_done();
        rd(7'h7F, 8, 32'h5A);
        rd(7'h00, 8, 32'h5A);
        ext(`TW_EXT_ERASE_ALL_CMD);
        poll_done();
        rd(7'h40, 8, 32'hFF);
    endtask

    task automatic t_disable();
        ext(`TW_EXT_DISABLE);
        cmd(`TW_OP_WRITE, 7'h03, 16'h0000, 1'b1);
        no_status();
        rd(7'h03, 8, 32'hFF);
    endtask

    // Width change needs link edges to pass its synchroniser
    task automatic set_width(input logic w);
        word_width_select = w;
        host.send(32'h0, 3);
        host.deselect();
    endtask

    task automatic t_wide();
        set_width(1'b1);
        ext(`TW_EXT_ENABLE);
        cmd(`TW_OP_WRITE, 7'h01, 16'h1234, 1'b1);
        poll_done();
        ext(`TW_EXT_DISABLE);
        rd(7'h01, 16, 32'h1234);
        set_width(1'b0);
        rd(7'h02, 16, 32'h1234);
    endtask

    task automatic finish_test();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        reset_n = 1'b0;
        word_width_select = 1'b0;
        repeat (5) @(posedge mclk);
        #1 reset_n = 1'b1;
        #100;
        t_power_up();
        t_write_read();
        t_erase();
        t_bulk();
        t_disable();
        t_wide();
        finish_test();
    end

    initial begin
        #300us;
        mismatches++;
        finish_test();
    end
endmodule

// [tb/tw_host.sv]
module tw_host (
    // Link drive
    output logic      link_clk,
    output logic      chip_select,
    output logic      serial_in,
    // From device
    input  wire logic data_out,
    input  wire logic data_out_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] rx;

    initial begin
        link_clk = 1'b0;
        chip_select = 1'b0;
        serial_in = 1'b0;
        rx = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One 3 ns link pulse, then a pause so the synchronised pin settles
    task automatic pulse(input logic b);
        serial_in = b;
        #3 link_clk = 1'b1;
        #3 link_clk = 1'b0;
        #60;
        // Released pin shows the inverse of the last bit
        rx = {rx[30:0], data_out_oe_n ? ~rx[0] : data_out};
    endtask

    // Frame of n bits, start bit at the top
    task automatic send(input logic [31:0] v, input int n);
        chip_select = 1'b1;
        #10;
        for (int i = n - 1; i >= 0; i--) begin
            pulse(v[i]);
        end
    endtask

    task automatic select();
        chip_select = 1'b1;
        #80;
    endtask

    task automatic deselect();
        chip_select = 1'b0;
        #300;
    endtask
endmodule
